// ==== hdl/sar_pkg.sv ====
// Purpose: constants, types and defaults for the sump alarm relay block
// Assumes: 20 MHz system clock, 9600 baud 8E1 serial link
// Notes:   register words are raw 16-bit; 32-bit values sit high word first
`default_nettype none
package sar_pkg;
    // clock and link timing
    localparam int          CLK_HZ      = 20_000_000;
    localparam int          BAUD        = 9600;
    localparam logic [11:0] BIT_CYC     = 12'(CLK_HZ / BAUD);
    localparam logic [11:0] HALF_CYC    = 12'(CLK_HZ / BAUD / 2);
    localparam int          SEC_S       = 1;
    localparam int          SEC_CYC_DEF = CLK_HZ * SEC_S;
    // silence of 3.5 characters of 11 bits ends a frame
    localparam int          GAP_CYC_DEF = (CLK_HZ * 77) / (BAUD * 2);

    // frame coding
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [7:0]  FC_READ  = 8'h03;
    localparam logic [7:0]  FC_WRITE = 8'h06;
    localparam logic [7:0]  EX_FUNC  = 8'h01;
    localparam logic [7:0]  EX_ADDR  = 8'h02;
    localparam logic [7:0]  EX_FLAG  = 8'h80;
    localparam logic [3:0]  REQ_LEN  = 4'h8;
    localparam int          NREG     = 50;

    // register word indices
    localparam logic [5:0] R_SERIAL = 6'h00, R_REV = 6'h02, R_SENS = 6'h03, R_STAT = 6'h04;
    localparam logic [5:0] R_MODEL = 6'h05, R_SETUP = 6'h06, R_PASS = 6'h07, R_PK1 = 6'h08;
    localparam logic [5:0] R_PK2 = 6'h0A, R_PK3 = 6'h0C, R_FILT = 6'h0E, R_SLOPE = 6'h10;
    localparam logic [5:0] R_OFFS = 6'h12, R_MSPAN = 6'h14, R_MZERO = 6'h16, R_MTSL = 6'h18;
    localparam logic [5:0] R_MTOF = 6'h1A, R_C1LV = 6'h1C, R_C2LV = 6'h1E, R_C1PF = 6'h20;
    localparam logic [5:0] R_C2PF = 6'h22, R_R1HI = 6'h24, R_R2HI = 6'h26, R_SETPT = 6'h28;
    localparam logic [5:0] R_R2LO = 6'h2A, R_DLY1 = 6'h2C, R_DLY2 = 6'h2D, R_MA = 6'h2E;
    localparam logic [5:0] R_FREQ = 6'h30;

    // relay setup byte fields, shared by both relays
    localparam int SU_ACT  = 0;
    localparam int SU_FS   = 1;
    localparam int SU_CALA = 2;
    // status word fields
    localparam int ST_ALM  = 0;
    localparam int ST_REL  = 1;
    localparam int ST_RAW  = 2;
    localparam int ST_CALA = 3;

    // factory values; sensitivity in tenths of a pF
    localparam logic [7:0]  DEF_SENS  = 8'h1E;
    localparam logic [7:0]  SENS_MAX  = 8'h96;
    localparam logic [7:0]  DEF_ID    = 8'h01;
    localparam logic [15:0] DEF_SETUP = 16'h0202;
    localparam logic [15:0] DEF_DLY   = 16'h0014;
    localparam logic [15:0] DEF_FILT  = 16'h0000;
    // arbitrary identity values
    localparam logic [7:0]  MODEL_CODE = 8'h5A;
    localparam logic [15:0] REV_CODE   = 16'h0101;

    typedef enum logic [0:0] {R_IDLE = 1'b0, R_BITS = 1'b1} sar_rx_t;
    typedef enum logic [0:0] {T_IDLE = 1'b0, T_SEND = 1'b1} sar_tx_t;
    typedef enum logic [1:0] {K_READ = 2'b00, K_WRITE = 2'b01, K_EXC = 2'b10} sar_kind_t;

    typedef struct packed {
        logic [2:0]        sy;
        logic              rxl;
        sar_rx_t           rst;
        logic [11:0]       rcyc;
        logic [3:0]        rbit;
        logic [8:0]        rsh;
        logic [16:0]       gap;
        logic [7:0][7:0]   fb;
        logic [3:0]        bcnt;
        logic              bad;
        logic [15:0]       rcrc;
        sar_tx_t           tst;
        logic [11:0]       tcyc;
        logic [3:0]        tbit;
        logic [10:0]       tsh;
        logic [6:0]        tidx;
        logic [6:0]        tlen;
        logic [15:0]       tcrc;
        sar_kind_t         kind;
        logic [7:0]        exc;
        logic [49:0][15:0] regs;
        logic [31:0]       filt;
        logic [24:0]       fcyc;
        logic [24:0]       dcyc;
        logic [15:0]       dsec;
        logic              alarm;
        logic              rel;
    } sar_state_t;

    // factory register image
    function automatic logic [49:0][15:0] def_regs();
        logic [49:0][15:0] r;
        r = '0;
        r[R_SENS]    = {DEF_SENS, 8'h00};
        r[R_MODEL]   = {MODEL_CODE, DEF_ID};
        r[R_SETUP]   = DEF_SETUP;
        r[R_FILT+1]  = DEF_FILT;
        r[R_DLY1]    = DEF_DLY;
        r[R_DLY2]    = DEF_DLY;
        return r;
    endfunction
endpackage
`default_nettype wire

// ==== hdl/sar_alarm_map.sv ====
// Purpose: alarm decision, relay drive and serial register map of the sump alarm
// Assumes: readings are unsigned words in one shared encoding; same-clock sources
// Notes:   half duplex; a frame arriving while an answer is sent is dropped
`timescale 1ns/100ps
`default_nettype none
module sar_alarm_map
    import sar_pkg::*;
#(
    parameter int          SEC_CYCLES = SEC_CYC_DEF,
    parameter int          GAP_CYCLES = GAP_CYC_DEF,
    parameter int          BIT_CYCLES = int'(BIT_CYC),
    parameter logic [31:0] SERIAL     = 32'h0000_0001
) (
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    input  wire logic        RS485_RX,
    output logic             RS485_TX,
    output logic             RS485_OE,
    input  wire logic [31:0] CAP_READING,
    input  wire logic [31:0] MA_OUT_VALUE,
    input  wire logic [31:0] OSC_FREQ,
    input  wire logic        RESTORE_DEFAULTS,
    output logic             RELAY1_ENERGIZE,
    output logic             RELAY2_ENERGIZE,
    output logic             ALARM_ACTIVE,
    output logic [31:0]      FILTERED_CAP
);
    sar_state_t  q;
    sar_state_t  d;
    logic        fend;
    logic        go;
    logic        raw;
    logic [31:0] sp;
    logic [7:0]  my_id;
    logic [7:0]  setup;

    // bit timing from the parameter so a bench may shorten it;
    // the default keeps the 9600 baud rate
    localparam logic [11:0] BIT_LEN  = 12'(BIT_CYCLES);
    localparam logic [11:0] BIT_HALF = 12'(BIT_CYCLES / 2);

    // async reset takes this constant image only
    function automatic sar_state_t rst_state();
        sar_state_t s;
        s      = '0;
        s.sy   = 3'h7;
        s.rxl  = 1'b1;
        s.tsh  = 11'h7FF;
        s.rcrc = CRC_INIT;
        s.regs = def_regs();
        return s;
    endfunction
    localparam sar_state_t RST_ST = rst_state();

    // one step of the reflected frame check
    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // words seen by the master; the status, mA and frequency words show live state
    function automatic logic [15:0] rd_word(input logic [5:0] a);
        unique case (a)
            R_SERIAL:     rd_word = SERIAL[31:16];
            R_SERIAL + 1: rd_word = SERIAL[15:0];
            R_REV:        rd_word = REV_CODE;
            R_STAT: begin
                rd_word = '0;
                rd_word[ST_ALM]  = q.alarm;
                rd_word[ST_REL]  = q.rel;
                rd_word[ST_RAW]  = raw;
                rd_word[ST_CALA] = setup[SU_CALA];
            end
            R_MA:         rd_word = MA_OUT_VALUE[31:16];
            R_MA + 1:     rd_word = MA_OUT_VALUE[15:0];
            R_FREQ:       rd_word = OSC_FREQ[31:16];
            R_FREQ + 1:   rd_word = OSC_FREQ[15:0];
            default:      rd_word = q.regs[a];
        endcase
    endfunction

    function automatic logic writable(input logic [5:0] a);
        return !(a <= R_REV || a == R_STAT || a >= R_MA);
    endfunction

    // byte k of the answer being sent
    function automatic logic [7:0] resp(input logic [6:0] k);
        logic [6:0]  off;
        logic [15:0] w;
        off = (k - 7'h03) >> 1;
        w   = rd_word(6'({q.fb[2], q.fb[3]} + {9'h000, off}));
        unique case (q.kind)
            K_WRITE: resp = q.fb[k[2:0]];
            K_EXC:   resp = (k == 7'h00) ? q.fb[0] : (k == 7'h01) ? (q.fb[1] | EX_FLAG) : q.exc;
            default: begin
                if (k < 7'h02) begin
                    resp = q.fb[k[2:0]];
                end else if (k == 7'h02) begin
                    resp = {q.fb[5][6:0], 1'b0};
                end else begin
                    resp = k[0] ? w[15:8] : w[7:0];
                end
            end
        endcase
    endfunction

    assign my_id = q.regs[R_MODEL][7:0];
    assign setup = q.regs[R_SETUP][7:0];

    // next-state logic for the whole block
    always_comb begin
        logic [15:0] ra;
        logic [15:0] rv;
        logic [7:0]  b;
        logic [7:0]  fsec;
        logic [31:0] diff;
        logic [31:0] step;
        d    = q;
        ra   = {q.fb[2], q.fb[3]};
        rv   = {q.fb[4], q.fb[5]};
        b    = 8'hFF;
        fsec = q.regs[R_FILT + 1][7:0];
        diff = '0;
        step = '0;
        sp   = {q.regs[R_SETPT], q.regs[R_SETPT + 1]};
        // raw first: the status word reads it through rd_word
        raw  = setup[SU_ACT] ? (q.filt > sp) : (q.filt < sp);

        // pin sync: a level counts once the last two stages agree
        d.sy = {q.sy[1:0], RS485_RX};
        if (q.sy[2] == q.sy[1]) begin
            d.rxl = q.sy[2];
        end

        // receiver, 8E1 sampled mid-bit
        unique case (q.rst)
            R_IDLE: begin
                if (!q.rxl) begin
                    d.rst  = R_BITS;
                    d.rcyc = BIT_HALF;
                    d.rbit = 4'h0;
                end
            end
            R_BITS: begin
                if (q.rcyc != 12'h000) begin
                    d.rcyc = q.rcyc - 12'h001;
                end else begin
                    d.rcyc = BIT_LEN - 12'h001;
                    d.rbit = q.rbit + 4'h1;
                    if (q.rbit == 4'h0 && q.rxl) begin
                        d.rst = R_IDLE; // start glitch
                    end else if (q.rbit >= 4'h1 && q.rbit <= 4'h9) begin
                        d.rsh = {q.rxl, q.rsh[8:1]};
                    end else if (q.rbit == 4'hA) begin
                        d.rst = R_IDLE;
                        // bad stop or odd parity spoils the frame
                        if (!q.rxl || ^q.rsh || q.bcnt >= REQ_LEN) begin
                            d.bad = 1'b1;
                        end else begin
                            d.fb[q.bcnt[2:0]] = q.rsh[7:0];
                        end
                        if (q.bcnt != 4'hF) begin
                            d.bcnt = q.bcnt + 4'h1;
                        end
                        d.rcrc = crc_upd(q.rcrc, q.rsh[7:0]);
                    end
                end
            end
        endcase

        // silence timer marks frame end
        if (q.rst != R_IDLE || !q.rxl) begin
            d.gap = '0;
        end else if (q.gap != 17'(GAP_CYCLES)) begin
            d.gap = q.gap + 17'h00001;
        end
        fend = q.gap == 17'(GAP_CYCLES - 1) && q.rst == R_IDLE && q.rxl && q.bcnt != 4'h0;
        // only whole, clean frames for this unit are served
        go = fend && q.tst == T_IDLE && !q.bad && q.bcnt == REQ_LEN && q.rcrc == 16'h0000
             && q.fb[0] == my_id;
        if (fend) begin
            d.bcnt = '0;
            d.bad  = 1'b0;
            d.rcrc = CRC_INIT;
        end

        // request decode
        if (go) begin
            d.kind = K_EXC;
            d.exc  = EX_ADDR;
            d.tlen = 7'h03;
            if (q.fb[1] == FC_READ) begin
                if (rv != 16'h0000 && ({1'b0, ra} + {1'b0, rv}) <= 17'(NREG)) begin
                    d.kind = K_READ;
                    d.tlen = 7'(16'h0003 + {rv[14:0], 1'b0});
                end
            end else if (q.fb[1] == FC_WRITE) begin
                if (ra < 16'(NREG) && writable(ra[5:0])) begin
                    d.kind = K_WRITE;
                    d.tlen = 7'h06;
                    d.regs[ra[5:0]] = rv;
                    if (ra[5:0] == R_SENS && rv[15:8] > SENS_MAX) begin
                        d.regs[R_SENS] = {SENS_MAX, rv[7:0]};
                    end
                    if (ra[5:0] == R_MODEL) begin
                        d.regs[R_MODEL] = {MODEL_CODE, rv[7:0]};
                    end
                end
            end else begin
                d.exc = EX_FUNC;
            end
            d.tst  = T_SEND;
            d.tidx = '0;
            d.tbit = '0;
            d.tcyc = '0;
            d.tcrc = CRC_INIT;
        end

        // transmitter: start, 8 data lsb first, even parity, stop
        unique case (q.tst)
            T_IDLE: d.tsh = 11'h7FF;
            T_SEND: begin
                if (q.tcyc != 12'h000) begin
                    d.tcyc = q.tcyc - 12'h001;
                end else if (q.tbit != 4'h0) begin
                    d.tsh  = {1'b1, q.tsh[10:1]};
                    d.tbit = q.tbit - 4'h1;
                    d.tcyc = BIT_LEN - 12'h001;
                end else if (q.tidx == q.tlen + 7'h02) begin
                    d.tst = T_IDLE;
                end else begin
                    if (q.tidx < q.tlen) begin
                        b      = resp(q.tidx);
                        d.tcrc = crc_upd(q.tcrc, b);
                    end else if (q.tidx == q.tlen) begin
                        b = q.tcrc[7:0];
                    end else begin
                        b = q.tcrc[15:8];
                    end
                    d.tsh  = {1'b1, ^b, b, 1'b0};
                    d.tbit = 4'hA;
                    d.tcyc = BIT_LEN - 12'h001;
                    d.tidx = q.tidx + 7'h01;
                end
            end
        endcase

        // smoothing: each second steps 1/fsec of the remaining gap toward the reading
        d.fcyc = (q.fcyc == 25'(SEC_CYCLES - 1)) ? '0 : q.fcyc + 25'h0000001;
        if (fsec == 8'h00) begin
            d.filt = CAP_READING;
        end else if (q.fcyc == 25'(SEC_CYCLES - 1)) begin
            diff = (CAP_READING >= q.filt) ? CAP_READING - q.filt : q.filt - CAP_READING;
            step = diff / {24'h000000, fsec};
            if (step == 32'h0) begin
                d.filt = CAP_READING; // avoids sticking short of the reading
            end else begin
                d.filt = (CAP_READING >= q.filt) ? q.filt + step : q.filt - step;
            end
        end

        // alarm decision from the shared setup byte
        if (!raw) begin
            d.dcyc  = '0;
            d.dsec  = '0;
            d.alarm = 1'b0;
        end else if (!q.alarm) begin
            if (q.dsec >= q.regs[R_DLY1]) begin
                d.alarm = 1'b1;
            end else if (q.dcyc == 25'(SEC_CYCLES - 1)) begin
                d.dcyc = '0;
                d.dsec = q.dsec + 16'h0001;
            end else begin
                d.dcyc = q.dcyc + 25'h0000001;
            end
        end
        d.rel = setup[SU_FS] ? !q.alarm : q.alarm;

        // restore wins over a same-cycle write
        if (RESTORE_DEFAULTS) begin
            d.regs = def_regs();
        end
    end

    // the single state register
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            q <= RST_ST;
        end else begin
            q <= d;
        end
    end

    // outputs come straight from state flops
    assign RS485_TX        = q.tsh[0];
    assign RS485_OE        = q.tst == T_SEND;
    assign RELAY1_ENERGIZE = q.rel;
    assign RELAY2_ENERGIZE = q.rel;
    assign ALARM_ACTIVE    = q.alarm;
    assign FILTERED_CAP    = q.filt;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!NRST);

    // decision, relay and link checks
    relay_pair_a:    assert property (RELAY1_ENERGIZE == RELAY2_ENERGIZE)
        else $error("relays differ");
    failsafe_norm_a: assert property (!q.alarm && setup[SU_FS] |=> RELAY1_ENERGIZE)
        else $error("failsafe relay not energized in normal");
    alarm_cause_a:   assert property ($rose(q.alarm) |->
        $past(raw) && $past(q.dsec) >= $past(q.regs[R_DLY1]))
        else $error("alarm before delay");
    alarm_clear_a:   assert property (!raw |=> !q.alarm)
        else $error("alarm held without cause");
    action_dir_a:    assert property ($rose(q.alarm) && !$past(setup[SU_ACT]) |-> $past(q.filt) < $past(sp))
        else $error("below action tripped wrong way");
    filter_off_a:    assert property (fsec_zero() |=> q.filt == $past(CAP_READING))
        else $error("unfiltered reading not passed");
    sens_max_a:      assert property (q.regs[R_SENS][15:8] <= SENS_MAX)
        else $error("sensitivity above limit");
    restore_a:       assert property (RESTORE_DEFAULTS |=>
        q.regs[R_DLY1] == DEF_DLY && q.regs[R_SETUP] == DEF_SETUP)
        else $error("defaults not restored");
    foreign_quiet_a: assert property (fend && q.fb[0] != my_id && q.tst == T_IDLE |=>
        q.tst == T_IDLE [*2])
        else $error("answered foreign id");
    line_idle_a:     assert property (!RS485_OE |-> RS485_TX)
        else $error("line not idle high");
    answer_start_a:  assert property (go |=> RS485_OE ##1 !RS485_TX)
        else $error("answer start bit missing");
    oe_quiet_a:      assert property (q.tst == T_IDLE && !go |=> !RS485_OE)
        else $error("driver enabled without request");
    model_fixed_a:   assert property (q.regs[R_MODEL][15:8] == MODEL_CODE)
        else $error("model byte changed");
    alarm_hold_a:    assert property (q.alarm && raw |=> q.alarm)
        else $error("alarm dropped while condition held");

    // filter seconds of zero mean pass-through
    function automatic logic fsec_zero();
        return q.regs[R_FILT + 1][7:0] == 8'h00;
    endfunction

    // main scenarios
    alarm_seen_c: cover property ($rose(q.alarm));
    read_seen_c:  cover property (go && q.fb[1] == FC_READ);
    write_seen_c: cover property (go && q.fb[1] == FC_WRITE ##1 q.kind == K_WRITE);
    exc_seen_c:   cover property (go ##1 q.kind == K_EXC);
    smooth_c:     cover property (!fsec_zero() && q.fcyc == 25'(SEC_CYCLES - 1));
endmodule
`default_nettype wire

// ==== tb/sar_master_model.sv ====
// Purpose: serial bus master that sends request frames and collects answers
// Assumes: line biased high while idle; 8E1 at the given bit time
// Notes:   answer collection ends after two character times of silence
`timescale 1ns/100ps
`default_nettype none
module sar_master_model
    import sar_pkg::*;
#(
    parameter int BIT_CYCLES = int'(BIT_CYC)
) (
    input  wire logic clk,
    input  wire logic dev_tx,
    input  wire logic dev_oe,
    output logic      bus_rx
);
    logic [7:0] ans[$];
    int         oe_cyc;
    int         ans_bad;

    // bias resistors hold the idle line high
    initial bus_rx = 1'b1;

    // running crc, low bit first
    function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] b);
        c = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    // one character: start, data lsb first, even parity, stop
    task automatic put_byte(input logic [7:0] b);
        logic [10:0] f;
        f = {1'b1, ^b, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            bus_rx = f[i];
            repeat (BIT_CYCLES) @(posedge clk);
            #1;
        end
    endtask

    // one clock, counting cycles with the unit's driver on
    task automatic tick();
        @(posedge clk);
        #1;
        if (dev_oe === 1'b1) oe_cyc++;
    endtask

    // whole request, then whatever comes back; the id selects the unit
    task automatic request(input logic [7:0] id, input logic [7:0] fc, input logic [15:0] a,
                           input logic [15:0] v);
        logic [7:0]  q[$];
        logic [15:0] c;
        logic [10:0] f;
        int          n;
        q = '{id, fc, a[15:8], a[7:0], v[15:8], v[7:0]};
        c = CRC_INIT;
        foreach (q[i]) c = crc_add(c, q[i]);
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i]) put_byte(q[i]);
        ans.delete();
        oe_cyc = 0;
        ans_bad = 0;
        // bounded: a unit that never falls silent cannot hang the run
        for (int k = 0; k < 64; k++) begin
            n = 0;
            while (dev_tx !== 1'b0 && n < 22 * BIT_CYCLES) begin
                tick();
                n++;
            end
            if (n >= 22 * BIT_CYCLES) break;
            // sample at mid bit so edge jitter of one cycle is harmless
            repeat (BIT_CYCLES / 2) tick();
            for (int i = 0; i < 11; i++) begin
                f[i] = dev_tx;
                if (i < 10) repeat (BIT_CYCLES) tick();
            end
            if (f[0] !== 1'b0 || f[10] !== 1'b1 || (^f[9:1]) !== 1'b0) ans_bad++;
            ans.push_back(f[8:1]);
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/sar_alarm_map_test.sv ====
// Purpose: self-checking bench for the alarm relays and serial register map
// Assumes: short second and gap counts keep alarm delays brief
// Notes:   bit time is scaled down too; the frame gap stays above half a bit
`timescale 1ns/100ps
`default_nettype none
module sar_alarm_map_test
    import sar_pkg::*;
    ;
    localparam int SECS    = 20;
    localparam int DLY_CYC = 20 * SECS; // factory delay of 20 s
    localparam int BIT_T   = 24;        // short bit time keeps frames brief

    logic        sys_clk, nrst, rs485_rx, rs485_tx, rs485_oe, restore, relay1, relay2, alarm;
    logic [31:0] cap, filt;
    int          err_count, check_count;

    sar_alarm_map #(.SEC_CYCLES(SECS), .GAP_CYCLES(100), .BIT_CYCLES(BIT_T)) uut (
        .SYS_CLK(sys_clk), .NRST(nrst), .RS485_RX(rs485_rx), .RS485_TX(rs485_tx), .RS485_OE(rs485_oe),
        .CAP_READING(cap), .MA_OUT_VALUE(32'h1234_5678), .OSC_FREQ(32'h0ABC_DEF0), .RESTORE_DEFAULTS(restore),
        .RELAY1_ENERGIZE(relay1), .RELAY2_ENERGIZE(relay2), .ALARM_ACTIVE(alarm), .FILTERED_CAP(filt));

    sar_master_model #(.BIT_CYCLES(BIT_T)) mst (.clk(sys_clk), .dev_tx(rs485_tx), .dev_oe(rs485_oe),
                                                .bus_rx(rs485_rx));

    // 20 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // inputs move 1 ns after the edge, never on it
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // whole answer, with crc residue and framing
    task automatic chk_answer(input logic [7:0] e[$]);
        logic [15:0] c;
        c = CRC_INIT;
        chk_word("answer length", 32'(e.size() + 2), 32'(mst.ans.size()));
        foreach (mst.ans[i]) c = mst.crc_add(c, mst.ans[i]);
        foreach (e[i]) chk_word("answer byte", {24'h0, e[i]}, {24'h0, mst.ans[i]});
        chk_word("answer crc residue", 32'h0, {16'h0, c});
        chk_word("answer framing errors", 32'h0, 32'(mst.ans_bad));
    endtask

    // alarm waits out the delay; a bound of twice the delay catches a hang
    task automatic alarm_after(input logic [31:0] c, input logic rel_exp);
        int n;
        n = 0;
        cap = c;
        while (alarm !== 1'b1 && n < 2 * DLY_CYC) begin
            step(1);
            n++;
        end
        chk_bit("alarm delay window", 1'b1, n >= DLY_CYC - 1 && n <= DLY_CYC + SECS);
        step(2);
        chk_bit("relay1 in alarm", rel_exp, relay1);
        chk_bit("relay2 in alarm", rel_exp, relay2);
    endtask

    // factory image at the relays and over the link
    task automatic t_defaults();
        chk_bit("relay1 energized", 1'b1, relay1);
        chk_bit("relay2 energized", 1'b1, relay2);
        cap = 32'h0000_0123;
        step(2);
        chk_word("filtered cap", 32'h0000_0123, filt);
        cap = 32'h0;
        mst.request(8'h01, FC_READ, 16'h0000, 16'h0008);
        chk_answer('{8'h01, FC_READ, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, REV_CODE[15:8], REV_CODE[7:0],
                     DEF_SENS, 8'h00, 8'h00, 8'h02, MODEL_CODE, DEF_ID, DEF_SETUP[15:8], DEF_SETUP[7:0],
                     8'h00, 8'h00});
        // live read-only words, then a refused write to the status word
        mst.request(8'h01, FC_READ, 16'h002E, 16'h0004);
        chk_answer('{8'h01, FC_READ, 8'h08, 8'h12, 8'h34, 8'h56, 8'h78, 8'h0A, 8'hBC, 8'hDE, 8'hF0});
        mst.request(8'h01, FC_WRITE, 16'h0004, 16'h00FF);
        chk_answer('{8'h01, FC_WRITE | EX_FLAG, EX_ADDR});
    endtask

    // setpoint lives in relay one's low word, low half here
    task automatic t_setpoint();
        cap = 32'h0000_0200; // above the new setpoint, so no delay runs early
        mst.request(8'h01, FC_WRITE, 16'h0029, 16'h0100);
        chk_answer('{8'h01, FC_WRITE, 8'h00, 8'h29, 8'h01, 8'h00});
    endtask

    // factory action below setpoint, failsafe relays
    task automatic t_below();
        alarm_after(32'h0000_0050, 1'b0);
        cap = 32'h0000_0200;
        step(4);
        chk_bit("alarm cleared", 1'b0, alarm);
        chk_bit("relay1 normal", 1'b1, relay1);
    endtask

    // another unit's id: silence and no setup change
    task automatic t_other_id();
        mst.request(8'h02, FC_WRITE, 16'h0006, 16'h0001);
        chk_word("foreign answer length", 32'h0, 32'(mst.ans.size()));
        chk_word("foreign enable cycles", 32'h0, 32'(mst.oe_cyc));
        chk_bit("relay1 after foreign write", 1'b1, relay1);
    endtask

    // action above, failsafe off; a reading at the setpoint trips neither way
    task automatic t_above();
        cap = 32'h0000_0100;
        mst.request(8'h01, FC_WRITE, 16'h0006, 16'h0001);
        chk_answer('{8'h01, FC_WRITE, 8'h00, 8'h06, 8'h00, 8'h01});
        chk_bit("no alarm at setpoint", 1'b0, alarm);
        chk_bit("relay1 idle non-failsafe", 1'b0, relay1);
        alarm_after(32'h0000_0200, 1'b1);
    endtask

    // filter of two seconds: the first second tick moves half way
    task automatic t_filter();
        mst.request(8'h01, FC_WRITE, 16'h000F, 16'h0002);
        chk_answer('{8'h01, FC_WRITE, 8'h00, 8'h0F, 8'h00, 8'h02});
        cap = 32'h0000_0300;
        step(SECS);
        chk_word("filter first step", 32'h0000_0280, filt);
    endtask

    // restore brings back setpoint zero and failsafe below action
    task automatic t_restore();
        restore = 1'b1;
        step(1);
        restore = 1'b0;
        cap = 32'h0000_0050;
        step(4);
        chk_bit("relay1 after restore", 1'b1, relay1);
        step(DLY_CYC + SECS);
        chk_bit("no alarm after restore", 1'b0, alarm);
    endtask

    task automatic report_and_stop();
        if (err_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        restore = 1'b0;
        cap = 32'h0;
        err_count = 0;
        check_count = 0;
        step(10);
        nrst = 1'b1;
        step(10);
        t_defaults();
        t_setpoint();
        t_below();
        t_other_id();
        t_above();
        t_filter();
        t_restore();
        report_and_stop();
    end
endmodule
`default_nettype wire
